/* src/return_with_immediate_rotate_defines.vh */
// Constants for the literal-return and rotate-through-carry execution unit
`ifndef RET_IMM_ROTATE_DEFINES_VH
`define RET_IMM_ROTATE_DEFINES_VH
`define OP_RETURN_WITH_IMMEDIATE 4'hd
`define OP_ROTATE_LEFT_THROUGH_CARRY 6'h0d
`define OP_HI_MSB 13
`define OP_HI_LSB 10
`define OP_ROT_MSB 13
`define OP_ROT_LSB 8
`define DEST_BIT 7
`define FADDR_MSB 6
`define LIT_MSB 7
`define PHASES_PER_CYCLE 3'h4
`define PHASE_LAST 2'h3
`define PC_RESET 13'h0000
`endif

/* src/return_literal_and_rotate_ops.v */
// Execution unit for literal return and rotate-left-through-carry
`default_nettype none
`include "return_with_immediate_rotate_defines.vh"
module return_literal_and_rotate_ops #(
   parameter PC_W = 13
) (
   input wire sys_clk, // Oscillator-rate clock
   input wire rst, // Asynchronous reset, active high
   input wire [13:0] instr, // Instruction word, held during its cycle
   input wire instr_valid, // Instruction present for execution
   input wire [7:0] file_rdata, // Contents of addressed file register
   input wire carry_in, // Current carry flag
   input wire [PC_W-1:0] stack_top_entry, // Return address at top of stack
   output reg [6:0] file_addr, // File register address
   output reg [7:0] file_wdata, // Data to write to file register
   output reg file_we, // File register write strobe
   output reg [7:0] acc_wdata, // Data to write to accumulator
   output reg acc_we, // Accumulator write strobe
   output reg carry_out, // New carry value
   output reg carry_we, // Carry write strobe
   output reg stack_pop, // Pop strobe to hardware stack
   output reg [PC_W-1:0] pc_load_value, // New program counter
   output reg pc_load, // Program counter load strobe
   output reg flush_nop, // Pipeline refill cycle in progress
   output reg cycle_end // Last oscillator period of an instruction cycle
);

   // Phases of one instruction cycle, one-hot; four oscillator periods per cycle
   localparam [3:0] PH_FIRST = 4'h1;
   localparam [3:0] PH_SECOND = 4'h2;
   localparam [3:0] PH_THIRD = 4'h4;
   localparam [3:0] PH_LAST = 4'h8;

   // Pipeline states, one-hot; the refill state swallows one instruction cycle
   localparam [1:0] RUN_NORMAL = 2'h1;
   localparam [1:0] RUN_REFILL = 2'h2;

   // Sequencer and decode signals
   reg [3:0] phase;
   reg [3:0] next_phase;
   reg [1:0] run_state;
   reg [1:0] next_run_state;
   wire last;
   wire refill;
   wire is_ret;
   wire is_rot;
   wire take_ret;
   wire take_rot;
   wire rot_to_file;
   wire rot_to_acc;
   wire [7:0] rotated;

   // Literal-return opcode match; the two don't-care bits are never looked at
   function is_return_op;
      input [13:0] word;
      begin
         is_return_op = (word[`OP_HI_MSB:`OP_HI_LSB] == `OP_RETURN_WITH_IMMEDIATE);
      end
   endfunction

   // Rotate opcode match; destination and address bits are left to the datapath
   function is_rotate_op;
      input [13:0] word;
      begin
         is_rotate_op = (word[`OP_ROT_MSB:`OP_ROT_LSB] == `OP_ROTATE_LEFT_THROUGH_CARRY);
      end
   endfunction

   // One step left through carry: old carry in at bit 0, bit 7 falls out
   function [7:0] rotate_left_carry;
      input [7:0] value;
      input carry;
      begin
         rotate_left_carry = {value[6:0], carry};
      end
   endfunction

   // Decode is gated off while the pipeline refills, so a fetched word is dropped
   assign last = (phase == PH_LAST);
   assign refill = (run_state == RUN_REFILL);
   assign is_ret = instr_valid && !refill && is_return_op(instr);
   assign is_rot = instr_valid && !refill && is_rotate_op(instr);

   // Work is committed only at the cycle's closing edge, once per instruction
   assign take_ret = last && is_ret;
   assign take_rot = last && is_rot;
   assign rot_to_file = take_rot && instr[`DEST_BIT];
   assign rot_to_acc = take_rot && !instr[`DEST_BIT];
   assign rotated = rotate_left_carry(file_rdata, carry_in);

   // Next phase: a fixed ring of four; an illegal code falls back to the first phase
   always @* begin
      next_phase = PH_FIRST;
      case (phase)
         PH_FIRST: begin
            next_phase = PH_SECOND;
         end
         PH_SECOND: begin
            next_phase = PH_THIRD;
         end
         PH_THIRD: begin
            next_phase = PH_LAST;
         end
         PH_LAST: begin
            next_phase = PH_FIRST;
         end
         default: begin
            next_phase = PH_FIRST;
         end
      endcase
   end

   // Phase register; cycle_end marks the last period so the core can align fetches
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase <= PH_FIRST;
         cycle_end <= 1'b0;
      end else begin
         phase <= next_phase;
         cycle_end <= (next_phase == PH_LAST);
      end
   end

   // Next pipeline state: a return costs a second, empty cycle for the refetch
   always @* begin
      next_run_state = run_state;
      case (run_state)
         RUN_NORMAL: begin
            if (take_ret) begin
               next_run_state = RUN_REFILL;
            end
         end
         RUN_REFILL: begin
            if (last) begin
               next_run_state = RUN_NORMAL;
            end
         end
         default: begin
            next_run_state = RUN_NORMAL;
         end
      endcase
   end

   // Pipeline state register; flush_nop mirrors the refill state for the core
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         run_state <= RUN_NORMAL;
         flush_nop <= 1'b0;
      end else begin
         run_state <= next_run_state;
         flush_nop <= (next_run_state == RUN_REFILL);
      end
   end

   // File address tracks the word every period so the register file can read early;
   // the rotate then sees settled read data by the cycle's closing edge
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         file_addr <= 7'h00;
      end else begin
         file_addr <= instr[`FADDR_MSB:0];
      end
   end

   // File write-back: only a rotate with destination 1 touches the register file
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         file_wdata <= 8'h00;
         file_we <= 1'b0;
      end else begin
         file_we <= rot_to_file;
         if (rot_to_file) begin
            file_wdata <= rotated;
         end
      end
   end

   // Accumulator write: the return's literal, or a rotate with destination 0;
   // both cannot fall in one cycle, since the opcodes are disjoint
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         acc_wdata <= 8'h00;
         acc_we <= 1'b0;
      end else begin
         acc_we <= take_ret || rot_to_acc;
         if (take_ret) begin
            acc_wdata <= instr[`LIT_MSB:0];
         end else if (rot_to_acc) begin
            acc_wdata <= rotated;
         end
      end
   end

   // Carry: the only status bit a rotate changes; the zero flag has no path here
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         carry_out <= 1'b0;
         carry_we <= 1'b0;
      end else begin
         carry_we <= take_rot;
         if (take_rot) begin
            carry_out <= file_rdata[7];
         end
      end
   end

   // Return control: pop the stack and reload the program counter together,
   // so the core never sees a popped stack with the old counter still in place
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stack_pop <= 1'b0;
         pc_load <= 1'b0;
         pc_load_value <= `PC_RESET;
      end else begin
         stack_pop <= take_ret;
         pc_load <= take_ret;
         if (take_ret) begin
            pc_load_value <= stack_top_entry;
         end
      end
   end
endmodule // return_literal_and_rotate_ops
`default_nettype wire

/* verification/rot_ret_monitor.sv */
// Checker for the literal-return and rotate unit
`default_nettype none
module rot_ret_monitor (
   input wire logic sys_clk, // Oscillator-rate clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic instr_valid, // Instruction present
   input wire logic carry_in, // Current carry flag
   input wire logic acc_we, // Accumulator write strobe
   input wire logic file_we, // File write strobe
   input wire logic carry_we, // Carry write strobe
   input wire logic carry_out, // New carry value
   input wire logic stack_pop, // Stack pop strobe
   input wire logic pc_load, // Program counter load strobe
   input wire logic flush_nop, // Refill cycle level
   input wire logic cycle_end, // Last period of a cycle
   input wire logic [13:0] instr, // Instruction word
   input wire logic [12:0] stack_top_entry, // Return address
   input wire logic [12:0] pc_load_value, // New program counter
   input wire logic [7:0] file_rdata, // File read data
   input wire logic [7:0] file_wdata, // File write data
   input wire logic [7:0] acc_wdata // Accumulator write data
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // Taken at a cycle's closing edge; nothing is taken while the pipe refills
   sequence s_r;
      cycle_end && instr_valid && !flush_nop && instr[13:10] == 4'hd;
   endsequence
   sequence s_l;
      cycle_end && instr_valid && !flush_nop && instr[13:8] == 6'h0d;
   endsequence
   // Closing edge of the refill cycle: whatever was fetched then must die
   sequence s_refill_end;
      flush_nop && cycle_end;
   endsequence
   property p_lit;
      s_r |=> acc_we && acc_wdata == $past(instr[7:0]);
   endproperty
   a_lit: assert property (p_lit) else $error("literal");
   property p_pop;
      s_r |=> stack_pop && pc_load && pc_load_value == $past(stack_top_entry);
   endproperty
   a_pop: assert property (p_pop) else $error("pop");
   property p_two;
      s_r |=> flush_nop [*4] ##1 !flush_nop;
   endproperty
   a_two: assert property (p_two) else $error("length");
   property p_rot;
      s_l |=> {carry_out, file_we ? file_wdata : acc_wdata} ==
         {$past(file_rdata), $past(carry_in)};
   endproperty
   a_rot: assert property (p_rot) else $error("rotate");
   property p_dst;
      s_l |=> carry_we && file_we == $past(instr[7]) && acc_we != file_we;
   endproperty
   a_dst: assert property (p_dst) else $error("dest");
   property p_one;
      s_l |=> !pc_load && !stack_pop && !flush_nop;
   endproperty
   a_one: assert property (p_one) else $error("single");
   property p_nop;
      s_refill_end |=> !acc_we && !file_we && !carry_we && !pc_load && !stack_pop;
   endproperty
   a_nop: assert property (p_nop) else $error("refill");
   property p_phase;
      cycle_end |=> !cycle_end [*3] ##1 cycle_end;
   endproperty
   a_phase: assert property (p_phase) else $error("phase");
   // Strobes only ever follow a cycle's closing edge, never mid-cycle
   property p_strobe;
      acc_we || file_we || carry_we || pc_load || stack_pop |-> $past(cycle_end);
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe timing");
endmodule // rot_ret_monitor
bind return_literal_and_rotate_ops rot_ret_monitor i_rot_ret_monitor (
   .sys_clk(sys_clk),
   .rst(rst),
   .instr_valid(instr_valid),
   .carry_in(carry_in),
   .acc_we(acc_we),
   .file_we(file_we),
   .carry_we(carry_we),
   .carry_out(carry_out),
   .stack_pop(stack_pop),
   .pc_load(pc_load),
   .flush_nop(flush_nop),
   .cycle_end(cycle_end),
   .instr(instr),
   .stack_top_entry(stack_top_entry),
   .pc_load_value(pc_load_value),
   .file_rdata(file_rdata),
   .file_wdata(file_wdata),
   .acc_wdata(acc_wdata)
);
`default_nettype wire

/* verification/return_literal_and_rotate_ops_tb.sv */
// Bench for the literal-return and rotate unit
`default_nettype none
module return_literal_and_rotate_ops_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, rst = 1, instr_valid = 1, carry_in = 0, acc_we, file_we, carry_we;
   logic carry_out, stack_pop, pc_load, flush_nop, cycle_end;
   logic [13:0] instr = 14'h0000;
   logic [12:0] stack_top_entry = 13'h1a5c, pc_load_value;
   logic [7:0] file_rdata = 8'h00, file_wdata, acc_wdata;
   logic [6:0] file_addr;
   int mismatches = 0, num_checks = 0;
   // Device under test
   return_literal_and_rotate_ops i_return_literal_and_rotate_ops (
      .sys_clk(sys_clk),
      .rst(rst),
      .instr(instr),
      .instr_valid(instr_valid),
      .file_rdata(file_rdata),
      .carry_in(carry_in),
      .stack_top_entry(stack_top_entry),
      .file_addr(file_addr),
      .file_wdata(file_wdata),
      .file_we(file_we),
      .acc_wdata(acc_wdata),
      .acc_we(acc_we),
      .carry_out(carry_out),
      .carry_we(carry_we),
      .stack_pop(stack_pop),
      .pc_load_value(pc_load_value),
      .pc_load(pc_load),
      .flush_nop(flush_nop),
      .cycle_end(cycle_end)
   );
   // Free-running 125 MHz clock
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   // One comparison; an unknown result counts as a mismatch
   task chk(input logic ok, input string what);
      num_checks++;
      if (ok !== 1'b1) begin
         $display("MISMATCH %0t %s", $time, what);
         mismatches++;
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Holds one instruction a whole cycle; returns once its results have landed
   task run(input logic [13:0] i, input logic [7:0] d, input logic c, input logic v);
      {instr, file_rdata, carry_in, instr_valid} = {i, d, c, v};
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   // Return, then a rotate fetched into the refill cycle that must be dropped
   task t_ret;
      run(14'h37ab, 8'hff, 1'b0, 1'b1);
      chk(acc_we && acc_wdata === 8'hab, "literal");
      chk(stack_pop && pc_load && pc_load_value === 13'h1a5c && flush_nop, "pop");
      run(14'h0d85, 8'hff, 1'b0, 1'b1);
      chk(!file_we && !carry_we && !acc_we && !flush_nop, "refill");
   endtask
   // Rotate to the file register, then to the accumulator
   task t_rot;
      run(14'h0d85, 8'h80, 1'b1, 1'b1);
      chk(file_we && file_wdata === 8'h01 && !acc_we, "to file");
      chk(carry_we && carry_out && !pc_load, "carry");
      chk(file_addr === 7'h05, "address");
      run(14'h0d7f, 8'h41, 1'b0, 1'b1);
      chk(acc_we && acc_wdata === 8'h82 && !carry_out && !file_we, "to acc");
   endtask
   // An invalid word and an unrelated opcode must both leave everything alone
   task t_idle;
      run(14'h37ab, 8'hff, 1'b1, 1'b0);
      chk(!acc_we && !stack_pop && !pc_load && !flush_nop, "invalid");
      run(14'h0985, 8'hff, 1'b1, 1'b1);
      chk(!acc_we && !file_we && !carry_we, "other opcode");
   endtask
   // Reset, then the scenarios back to back
   initial begin
      repeat (12) @(posedge sys_clk);
      #1 rst = 0;
      t_ret;
      t_rot;
      t_idle;
      tally_and_finish;
   end
endmodule // return_literal_and_rotate_ops_tb
`default_nettype wire
